// *** common/adcpf_pkg.sv ***
// Purpose: shared constants for the scan and compare controller
// Assumes: 8-bit register port, ten channels, ten-bit results
// Notes: offsets are word indices on the plain register port
package adcpf_pkg;
  localparam int unsigned NUM_CH = 10;
  localparam int unsigned RES_W = 10;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 8;
  // register offsets
  localparam logic [4:0] OFF_MODE = 5'h00;
  localparam logic [4:0] OFF_CHSEL = 5'h01;
  localparam logic [4:0] OFF_CMPMODE = 5'h02;
  localparam logic [4:0] OFF_THRESH = 5'h03;
  localparam logic [4:0] OFF_STATUS = 5'h04;
  localparam logic [4:0] OFF_RES_BASE = 5'h08;
  // mode_control_0 fields
  localparam int unsigned MODE_CE_BIT = 7;
  localparam int unsigned MODE_MD_LSB = 4;
  localparam logic [1:0] MD_CONT_SEL = 2'h0;
  localparam logic [1:0] MD_CONT_SCAN = 2'h1;
  localparam logic [1:0] MD_ONESHOT = 2'h2;
  // compare_mode_reg fields
  localparam int unsigned CMP_EN_BIT = 7;
  localparam int unsigned CMP_COND_BIT = 6;
  // status fields
  localparam int unsigned ST_ACTIVE_BIT = 7;
  localparam int unsigned ST_IRQF_BIT = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] CH_FIRST = 4'h0;
  // conversion time
  localparam int unsigned CONV_TIME_NS = 2000;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : adcpf_pkg

// *** src/adcpf_conv_timer.sv ***
// Purpose: paces one conversion and pulses done at its end
// Assumes: conv_code_i from the analog front end is stable at done
// Notes: restart re-arms the count from zero
`timescale 1ns/1ps
`default_nettype none
module adcpf_conv_timer import adcpf_pkg::*; #(
  parameter int unsigned CYCLES = CONV_CYC
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire logic abort_i,
  output logic busy_o,
  output logic done_o
);
  localparam int unsigned CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_r;

  initial begin
    if (CYCLES < 2) $error("conversion needs at least two cycles");
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i || abort_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      cnt_r <= '0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        busy_o <= 1'b1;
        cnt_r <= '0;
      end else if (busy_o) begin
        if (cnt_r == CW'(CYCLES - 1)) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt_r <= cnt_r + CW'(1);
        end
      end
    end
  end
endmodule : adcpf_conv_timer
`default_nettype wire

// *** src/adcpf_ctrl.sv ***
// Purpose: scan sequencing, threshold compare and end-of-conversion flag
// Assumes: software trigger only; front end gives ten-bit code on done
// Notes: registers on a plain strobe port, read data one cycle later
//
// How it works
// - one-shot scan converts channel 0 up to selected channel, storing each result
// - one-shot scan raises end interrupt after last channel, then stops
// - compare disabled: interrupt after every conversion in continuous select, after the last channel in scans
// - compare on, condition 0: interrupt when high byte >= threshold
// - compare on, condition 1: interrupt when high byte < threshold
// - continuous select compare: always store, interrupt on match, run until disabled
// - continuous scan compare: only channel 0 compared, others stored, restart
// - continuous scan: after channel 0, convert further channels, then channel 0 again
// - one-shot scan compare: compare channel 0 only, store all, stop once
// - clearing converter enable halts conversion to save power
// - rewriting channel select leaves interrupt flag untouched
// - conversion-active bit set when a conversion starts
// - writing mode, select, compare or threshold mid-conversion restarts it
`timescale 1ns/1ps
`default_nettype none
module adcpf_ctrl import adcpf_pkg::*; #(
  parameter int unsigned CONV_CYCLES = CONV_CYC
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire logic [RES_W-1:0] conv_code_i,
  output logic [3:0] mux_sel_o,
  output logic sample_o,
  output logic conv_active_o,
  output logic conv_end_irq_o
);
  typedef enum logic [2:0] {
    ADCPF_IDLE = 3'b001,
    ADCPF_CONV = 3'b010,
    ADCPF_NEXT = 3'b100
  } adcpf_state_t;

  adcpf_state_t state_r;
  logic [7:0] mode_control_0_r;
  logic [3:0] channel_select_reg_r;
  logic [7:0] compare_mode_reg_r;
  logic [7:0] compare_threshold_reg_r;
  logic conversion_irq_flag_r;
  logic [3:0] cur_ch_r;
  logic [RES_W-1:0] channel_result_reg_r [NUM_CH];
  logic start_r;
  logic busy;
  logic done;
  logic cfg_wr;
  logic converter_enable;
  logic [1:0] md;
  logic compare_enable;
  logic compare_condition;
  logic [7:0] result_high_byte;
  logic cmp_hit;
  logic irq_fire;
  logic last_ch;
  logic flag_clr;
  logic parked;

  function automatic logic is_cfg(input logic [ADDR_W-1:0] a);
    return (a == OFF_MODE) || (a == OFF_CHSEL) || (a == OFF_CMPMODE) || (a == OFF_THRESH);
  endfunction : is_cfg

  assign converter_enable = mode_control_0_r[MODE_CE_BIT];
  assign md = mode_control_0_r[MODE_MD_LSB +: 2];
  assign compare_enable = compare_mode_reg_r[CMP_EN_BIT];
  assign compare_condition = compare_mode_reg_r[CMP_COND_BIT];
  assign cfg_wr = wr_i && is_cfg(addr_i);
  assign result_high_byte = conv_code_i[RES_W-1 -: 8];
  assign last_ch = (md == MD_CONT_SEL) || (cur_ch_r >= channel_select_reg_r);
  // a finished one-shot ignores config writes; only an enable toggle re-runs it
  assign parked = (state_r == ADCPF_CONV) && !busy && !start_r && !done;

  assign cmp_hit = compare_condition ? (result_high_byte < compare_threshold_reg_r)
                                     : (result_high_byte >= compare_threshold_reg_r);

  always_comb begin
    irq_fire = 1'b0;
    if (done) begin
      if (!compare_enable) begin
        // scans interrupt only at end of pass
        irq_fire = last_ch;
      end else if (md == MD_CONT_SEL) begin
        irq_fire = cmp_hit;
      end else begin
        // scan modes judge channel 0 alone
        irq_fire = (cur_ch_r == CH_FIRST) && cmp_hit;
      end
    end
  end

  adcpf_conv_timer #(
    .CYCLES(CONV_CYCLES)
  ) u_timer (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .start_i(start_r),
    .abort_i(cfg_wr),
    .busy_o(busy),
    .done_o(done)
  );

  // configuration registers
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      mode_control_0_r <= RST_BYTE;
      channel_select_reg_r <= CH_FIRST;
      compare_mode_reg_r <= RST_BYTE;
      compare_threshold_reg_r <= RST_BYTE;
    end else if (wr_i) begin
      unique case (addr_i)
        OFF_MODE: mode_control_0_r <= wdata_i;
        // channels beyond nine are clamped so scans never run off the result array
        OFF_CHSEL: channel_select_reg_r <= (wdata_i[3:0] > 4'(NUM_CH - 1)) ?
                                           4'(NUM_CH - 1) : wdata_i[3:0];
        OFF_CMPMODE: compare_mode_reg_r <= wdata_i;
        OFF_THRESH: compare_threshold_reg_r <= wdata_i;
        default: ;
      endcase
    end
  end

  // sequencer
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_r <= ADCPF_IDLE;
      cur_ch_r <= CH_FIRST;
      start_r <= 1'b0;
    end else begin
      start_r <= 1'b0;
      if (!converter_enable || (cfg_wr && addr_i == OFF_MODE && !wdata_i[MODE_CE_BIT])) begin
        state_r <= ADCPF_IDLE;
        start_r <= 1'b0;
      end else if (cfg_wr && !parked) begin
        // back through idle so the pass restarts with the new settings
        state_r <= ADCPF_IDLE;
      end else begin
        unique case (state_r)
          ADCPF_IDLE: begin
            // entered on enable or restart; picks up settings written just before
            state_r <= ADCPF_NEXT;
            cur_ch_r <= (md == MD_CONT_SEL) ? channel_select_reg_r : CH_FIRST;
          end
          ADCPF_NEXT: begin
            start_r <= 1'b1;
            state_r <= ADCPF_CONV;
          end
          ADCPF_CONV: begin
            if (done) begin
              if (md == MD_CONT_SEL) begin
                state_r <= ADCPF_NEXT;
              end else if (!last_ch) begin
                cur_ch_r <= cur_ch_r + 4'h1;
                state_r <= ADCPF_NEXT;
              end else if (md == MD_CONT_SCAN) begin
                cur_ch_r <= CH_FIRST;
                state_r <= ADCPF_NEXT;
              end else begin
                state_r <= ADCPF_CONV; // parked
              end
            end
          end
          default: state_r <= ADCPF_IDLE;
        endcase
      end
    end
  end

  // results always stored regardless of compare outcome
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        channel_result_reg_r[i] <= '0;
      end
    end else if (done) begin
      channel_result_reg_r[cur_ch_r] <= conv_code_i;
    end
  end

  // interrupt flag: set beats clear; select writes do not touch it
  assign flag_clr = wr_i && (addr_i == OFF_STATUS) && !wdata_i[ST_IRQF_BIT];
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      conversion_irq_flag_r <= 1'b0;
      conv_end_irq_o <= 1'b0;
    end else begin
      conv_end_irq_o <= irq_fire;
      if (irq_fire) begin
        conversion_irq_flag_r <= 1'b1;
      end else if (flag_clr) begin
        conversion_irq_flag_r <= 1'b0;
      end
    end
  end

  // front end drive
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      mux_sel_o <= CH_FIRST;
      sample_o <= 1'b0;
      conv_active_o <= 1'b0;
    end else begin
      mux_sel_o <= cur_ch_r;
      sample_o <= start_r;
      conv_active_o <= busy || start_r;
    end
  end

  // read port
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rdata_o <= RST_BYTE;
    end else if (rd_i) begin
      rdata_o <= RST_BYTE;
      if (addr_i == OFF_MODE) begin
        rdata_o <= mode_control_0_r;
      end else if (addr_i == OFF_CHSEL) begin
        rdata_o <= {4'h0, channel_select_reg_r};
      end else if (addr_i == OFF_CMPMODE) begin
        rdata_o <= compare_mode_reg_r;
      end else if (addr_i == OFF_THRESH) begin
        rdata_o <= compare_threshold_reg_r;
      end else if (addr_i == OFF_STATUS) begin
        rdata_o[ST_ACTIVE_BIT] <= busy || start_r;
        rdata_o[ST_IRQF_BIT] <= conversion_irq_flag_r;
      end else if (addr_i >= OFF_RES_BASE && addr_i < OFF_RES_BASE + ADDR_W'(NUM_CH)) begin
        // high byte only; full code is not readable on an 8-bit port
        rdata_o <= channel_result_reg_r[4'(addr_i - OFF_RES_BASE)][RES_W-1 -: 8];
      end
    end
  end
endmodule : adcpf_ctrl
`default_nettype wire

// *** sim/adcpf_props.sv ***
// Purpose: port checks of adcpf_ctrl
// Assumes: one clock, sync reset
// Notes: shadows copy config writes
`timescale 1ns/1ps
`default_nettype none
module adcpf_props import adcpf_pkg::*; #(
  parameter int unsigned CONV_CYCLES = CONV_CYC
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic [RES_W-1:0] conv_code_i,
  input wire logic [3:0] mux_sel_o,
  input wire logic sample_o,
  input wire logic conv_active_o,
  input wire logic conv_end_irq_o
);
  logic [7:0] cmp_r;
  logic [7:0] thr_r;
  logic [1:0] md_r;
  logic [3:0] chsel_r;
  logic [7:0] hb;
  assign hb = conv_code_i[9:2];
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cmp_r <= RST_BYTE;
      thr_r <= RST_BYTE;
      md_r <= 2'h0;
      chsel_r <= CH_FIRST;
    end else if (wr_i) begin
      if (addr_i == OFF_CHSEL) begin
        chsel_r <= (wdata_i[3:0] > 4'(NUM_CH - 1)) ? 4'(NUM_CH - 1) : wdata_i[3:0];
      end
      if (addr_i == OFF_CMPMODE) cmp_r <= wdata_i;
      if (addr_i == OFF_THRESH) thr_r <= wdata_i;
      if (addr_i == OFF_MODE) md_r <= wdata_i[MODE_MD_LSB +: 2];
    end
  end
  property p_irq_pulse; conv_end_irq_o |=> !conv_end_irq_o; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq too wide");
  property p_act; sample_o |-> conv_active_o; endproperty
  a_act: assert property (p_act) else $error("sample while idle");
  property p_rose; $rose(conv_active_o) |-> sample_o; endproperty
  a_rose: assert property (p_rose) else $error("active without sample");
  // a write just before a start aborts it and may restart quickly
  property p_gap; !wr_i ##1 sample_o ##1 (!wr_i) [*3] |-> !sample_o; endproperty
  a_gap: assert property (p_gap) else $error("conversion too short");
  // late irq across a mode change is skipped, compare state is then stale
  property p_cond;
    conv_end_irq_o && md_r == MD_CONT_SEL && $past(md_r, 3) == MD_CONT_SEL |->
      !cmp_r[CMP_EN_BIT] || (cmp_r[CMP_COND_BIT] ? $past(hb) < thr_r : $past(hb) >= thr_r);
  endproperty
  a_cond: assert property (p_cond) else $error("irq without match");
  // end of the last channel of a one-shot pass, not disturbed by a restart write
  property p_once;
    $fell(conv_active_o) && md_r == MD_ONESHOT && mux_sel_o == chsel_r && !wr_i && !$past(wr_i)
      |=> !sample_o [*8];
  endproperty
  a_once: assert property (p_once) else $error("one-shot kept going");
  property p_stop;
    wr_i && addr_i == OFF_MODE && !wdata_i[MODE_CE_BIT] |=> ##2 (!conv_active_o && !sample_o) [*4];
  endproperty
  a_stop: assert property (p_stop) else $error("still converting");
  property p_restart; wr_i && addr_i == OFF_THRESH && conv_active_o |-> ##[1:4] sample_o; endproperty
  a_restart: assert property (p_restart) else $error("no restart");
  property p_keep;
    rd_i && addr_i == OFF_STATUS ##1 rdata_o[ST_IRQF_BIT] ##1 wr_i && addr_i == OFF_CHSEL
      ##2 rd_i && addr_i == OFF_STATUS |=> rdata_o[ST_IRQF_BIT];
  endproperty
  a_keep: assert property (p_keep) else $error("flag lost");
endmodule : adcpf_props
`default_nettype wire

// *** sim/adcpf_afe_model.sv ***
// Purpose: analog front end stand-in
// Assumes: bench picks a code per channel
// Notes: code held from sample to next sample
`timescale 1ns/1ps
`default_nettype none
module adcpf_afe_model import adcpf_pkg::*; (
  input wire logic clk_i,
  input wire logic [3:0] mux_sel_i,
  input wire logic sample_i,
  input wire logic [RES_W-1:0] tab_i [NUM_CH],
  output logic [RES_W-1:0] code_o
);
  // hold level like the hold capacitor does
  always_ff @(posedge clk_i) begin
    if (sample_i) code_o <= tab_i[mux_sel_i];
  end
endmodule : adcpf_afe_model
`default_nettype wire

// *** sim/adcpf_ctrl_tb_top.sv ***
// Purpose: self-checking bench of adcpf_ctrl
// Assumes: conversion count cut to 4
// Notes: random codes, fixed seed
`timescale 1ns/1ps
`default_nettype none
module adcpf_ctrl_tb_top import adcpf_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [DATA_W-1:0] rdata_o;
  logic [RES_W-1:0] conv_code_i;
  logic [3:0] mux_sel_o;
  logic sample_o;
  logic conv_active_o;
  logic conv_end_irq_o;
  logic [RES_W-1:0] tab [NUM_CH];
  logic [7:0] d;
  logic [7:0] cm;
  logic [7:0] thr;
  logic [3:0] ch;
  int mismatches = 0;
  int n_tests = 0;
  int seed = 32'hf564;
  int irqs = 0;
  int cyc = 0;
  int k;
  adcpf_ctrl #(.CONV_CYCLES(4)) adcpf_ctrl_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .conv_code_i(conv_code_i), .mux_sel_o(mux_sel_o), .sample_o(sample_o),
    .conv_active_o(conv_active_o), .conv_end_irq_o(conv_end_irq_o));
  adcpf_afe_model adcpf_afe_model_inst (.clk_i(clk_i), .mux_sel_i(mux_sel_o),
    .sample_i(sample_o), .tab_i(tab), .code_o(conv_code_i));
  initial forever #10 clk_i = ~clk_i;
  function automatic logic [7:0] hb(input logic [3:0] c);
    return tab[c][9:2];
  endfunction : hb
  function automatic logic hit(input logic [7:0] h, input logic [7:0] t, input logic [7:0] c);
    return !c[7] || (c[6] ? h < t : h >= t);
  endfunction : hit
  task automatic final_report();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    v = rdata_o;
  endtask : rd
  // irq count over n cycles, read off the edge to avoid racing the counter
  task automatic run(input int n, output int c);
    @(negedge clk_i);
    c = irqs;
    repeat (n) @(negedge clk_i);
    c = irqs - c;
  endtask : run
  task automatic newtab();
    for (int i = 0; i < NUM_CH; i++) tab[i] = RES_W'($random(seed));
    ch = 4'(1 + $unsigned($random(seed)) % 9);
  endtask : newtab
  always @(posedge clk_i) begin
    cyc++;
    if (conv_end_irq_o === 1'b1) irqs++;
    if (cyc == 6000) begin
      mismatches++;
      final_report();
    end
  end
  initial begin
    newtab();
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    for (int a = 0; a < 32; a++) begin
      rd(5'(a), d);
      chk(d, 8'h00);
    end
    $display("reset values done");
    for (int i = 0; i < 6; i++) begin
      newtab();
      thr = (i % 3 == 1) ? hb(ch) : 8'($random(seed));
      cm = (i % 3 == 0) ? 8'h00 : (i < 3 ? 8'h80 : 8'hC0);
      wr(OFF_CHSEL, {4'h0, ch});
      wr(OFF_CMPMODE, cm);
      wr(OFF_THRESH, thr);
      wr(OFF_MODE, 8'h80);
      run(4, k);
      rd(OFF_STATUS, d);
      chk(d & 8'h80, 8'h80);
      wr(OFF_THRESH, thr);
      run(60, k);
      wr(OFF_MODE, 8'h00);
      chk(8'(k > 0), 8'(hit(hb(ch), thr, cm)));
      run(10, k);
      chk(8'(k), 8'h00);
      rd(OFF_RES_BASE + 5'(ch), d);
      chk(d, hb(ch));
      wr(OFF_STATUS, 8'h00);
    end
    $display("select compare done");
    newtab();
    wr(OFF_CHSEL, {4'h0, ch});
    wr(OFF_CMPMODE, 8'h80);
    wr(OFF_THRESH, hb(0));
    wr(OFF_MODE, 8'hA0);
    run(20 * NUM_CH, k);
    chk(8'(k), 8'h01);
    for (int c = 0; c <= ch; c++) begin
      rd(OFF_RES_BASE + 5'(c), d);
      chk(d, hb(4'(c)));
    end
    rd(OFF_STATUS, d);
    wr(OFF_CHSEL, 8'h02);
    rd(OFF_STATUS, d);
    chk(d, 8'h01);
    wr(OFF_STATUS, 8'h00);
    rd(OFF_STATUS, d);
    chk(d, 8'h00);
    wr(OFF_MODE, 8'h00);
    $display("one-shot done");
    for (int i = 0; i < 2; i++) begin
      newtab();
      thr = i ? 8'hFF : 8'h00;
      wr(OFF_CHSEL, {4'h0, ch});
      wr(OFF_CMPMODE, 8'hC0);
      wr(OFF_THRESH, thr);
      wr(OFF_MODE, 8'h90);
      run(30 * NUM_CH, k);
      wr(OFF_MODE, 8'h00);
      chk(8'(k > 0), 8'(hit(hb(0), thr, 8'hC0)));
      for (int c = 0; c <= ch; c++) begin
        rd(OFF_RES_BASE + 5'(c), d);
        chk(d, hb(4'(c)));
      end
      wr(OFF_STATUS, 8'h00);
    end
    $display("scan compare done");
    final_report();
  end
endmodule : adcpf_ctrl_tb_top
bind adcpf_ctrl adcpf_props #(.CONV_CYCLES(CONV_CYCLES)) adcpf_props_inst (.clk_i(clk_i),
  .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .conv_code_i(conv_code_i), .mux_sel_o(mux_sel_o),
  .sample_o(sample_o), .conv_active_o(conv_active_o), .conv_end_irq_o(conv_end_irq_o));
`default_nettype wire
